// ---- hw/fcs_sequencer.sv ----
// fcs_sequencer: command sequencer of the embedded flash controller
// assumes: array model answers reads one cycle later, all inputs synchronous
`timescale 1ns/10ps
module fcs_sequencer
    import fcs_pkg::*;
#(
    parameter int PROG_CYC = FCS_PROG_CYC,
    parameter int ERASE_CYC = FCS_ERASE_CYC
)(
    input wire logic clock_i,
    input wire logic rst_i,
    input wire fcs_reg_req_t reg_i,
    output logic [31:0] reg_rdata_o,
    input wire fcs_hsb_req_t hsb_i,
    output fcs_arr_req_t arr_o,
    input wire logic [31:0] arr_rdata_i,
    input wire logic sec_bit_i,
    output logic sec_erase_o,
    output logic vol_wipe_o,
    output logic [FCS_FUSE_W-1:0] fuses_o,
    output logic irq_o
);
    // -------------------------------------------------------------------
    // declarations
    // -------------------------------------------------------------------
    fcs_state_t state_ff;
    logic [31:0] pbuf_ff [FCS_WORDS];
    logic [FCS_PAGE_NUMBER_FIELD_W-1:0] page_number_field_ff;
    logic [FCS_CMD_W-1:0] cmd_ff;
    logic [FCS_FUSE_W-1:0] fuse_ff;
    logic [FCS_CNT_W-1:0] cnt_ff;
    logic [FCS_WORD_W:0] widx_ff;
    logic rdy_ff, pge_ff, lck_ff, qpr_ff, qacc_ff, rd_pend_ff, wipe_ph_ff;
    logic rdy_ie_ff, lck_ie_ff, pge_ie_ff, qirq_ff;
    logic [31:0] rdata_ff;
    logic cmd_wr, key_ok, cmd_known, accept, bad_cmd, busy_hit;
    logic page_locked, wipe_locked, pbuf_wr, cmd_done, lck_set;
    logic [FCS_PAGE_W-1:0] tgt_page;
    logic [FCS_REGION_W-1:0] tgt_region;
    logic [FCS_BP_W-1:0] boot_area_protect_fuses;
    logic [FCS_PAGE_W:0] boot_pages;
    logic [FCS_CMD_W-1:0] wr_cmd;
    // -------------------------------------------------------------------
    // command decode
    // -------------------------------------------------------------------
    // keyed command write on the register port
    assign cmd_wr = reg_i.wr && (reg_i.addr == FCS_OFS_CMD);
    assign wr_cmd = reg_i.wdata[FCS_CMD_W-1:0];
    assign key_ok = reg_i.wdata[31:FCS_KEY_LSB] == FCS_KEY;
    assign cmd_known = (wr_cmd == FCS_C_WP) || (wr_cmd == FCS_C_EP) ||
        (wr_cmd == FCS_C_CPB) || (wr_cmd == FCS_C_LP) || (wr_cmd == FCS_C_UP) ||
        (wr_cmd == FCS_C_EA) || (wr_cmd == FCS_C_QPR);
    assign busy_hit = cmd_wr && (state_ff != FCS_IDLE);
    assign bad_cmd = cmd_wr && !busy_hit && !(key_ok && cmd_known);
    assign accept = cmd_wr && !busy_hit && key_ok && cmd_known;
    // target page and its protection
    assign tgt_page = page_number_field_ff[FCS_PAGE_W-1:0];
    assign tgt_region = tgt_page[FCS_PAGE_W-1 -: FCS_REGION_W];
    assign boot_area_protect_fuses = fuse_ff[FCS_BP_LSB +: FCS_BP_W];
    // boot area holds 128>>boot_area_protect_fuses pages; code 7 protects none
    assign boot_pages = (boot_area_protect_fuses == 3'h7) ? 10'h000 :
        (10'h080 >> boot_area_protect_fuses);
    // user page sits outside the regions and boot area
    assign page_locked = (tgt_page != FCS_USER_PAGE_SEL) &&
        (!fuse_ff[tgt_region] || ({1'b0, tgt_page} < boot_pages));
    assign wipe_locked = (fuse_ff[FCS_REGIONS-1:0] != 16'hFFFF) ||
        (boot_area_protect_fuses != 3'h7);
    // page buffer writes come from the high speed bus
    assign pbuf_wr = hsb_i.wr && !hsb_i.idle;
    // -------------------------------------------------------------------
    // sequencer state machine
    // -------------------------------------------------------------------
    // long counts are parameters so simulations can shorten them
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            state_ff <= FCS_IDLE;
            cmd_ff <= FCS_C_NOP;
            cnt_ff <= '0;
            widx_ff <= '0;
            qacc_ff <= 1'b0;
            rd_pend_ff <= 1'b0;
            wipe_ph_ff <= 1'b0;
        end
        else
        begin
            unique case (state_ff)
                FCS_IDLE:
                begin
                    if (accept)
                    begin
                        state_ff <= FCS_PEND;
                        cmd_ff <= wr_cmd;
                    end
                end
                FCS_PEND:
                begin
                    // wait for an idle bus cycle before touching the array
                    if (hsb_i.idle)
                    begin
                        cnt_ff <= '0;
                        widx_ff <= '0;
                        qacc_ff <= 1'b1;
                        rd_pend_ff <= 1'b0;
                        wipe_ph_ff <= 1'b0;
                        if ((cmd_ff == FCS_C_WP || cmd_ff == FCS_C_EP) && page_locked)
                            state_ff <= FCS_IDLE;
                        else if (cmd_ff == FCS_C_EA && wipe_locked)
                            state_ff <= FCS_IDLE;
                        else if (cmd_ff == FCS_C_WP)
                            state_ff <= FCS_PROG;
                        else if (cmd_ff == FCS_C_EP)
                            state_ff <= FCS_ERASE;
                        else if (cmd_ff == FCS_C_EA)
                            state_ff <= FCS_WIPE;
                        else if (cmd_ff == FCS_C_QPR)
                            state_ff <= FCS_QCHK;
                        else
                            state_ff <= FCS_FUSEW;
                    end
                end
                FCS_PROG, FCS_ERASE:
                begin
                    if (cnt_ff == FCS_CNT_W'((state_ff == FCS_PROG ? PROG_CYC : ERASE_CYC) - 1))
                        state_ff <= FCS_IDLE;
                    else
                        cnt_ff <= cnt_ff + 1'b1;
                end
                FCS_WIPE:
                begin
                    // volatile wipe first, then array, then fuses and security bit together in the last cycle
                    wipe_ph_ff <= 1'b1;
                    if (cnt_ff == FCS_CNT_W'(ERASE_CYC - 1))
                        state_ff <= FCS_IDLE;
                    else
                        cnt_ff <= cnt_ff + 1'b1;
                end
                FCS_QCHK:
                begin
                    // one read issued per cycle, data back one cycle later
                    rd_pend_ff <= !widx_ff[FCS_WORD_W];
                    if (!widx_ff[FCS_WORD_W])
                        widx_ff <= widx_ff + 1'b1;
                    if (rd_pend_ff)
                        qacc_ff <= qacc_ff & (&arr_rdata_i);
                    if (widx_ff[FCS_WORD_W] && !rd_pend_ff)
                        state_ff <= FCS_IDLE;
                end
                FCS_FUSEW:
                    state_ff <= FCS_IDLE;
            endcase
        end
    end
    // completion pulse when a running command returns to idle
    assign cmd_done = (state_ff != FCS_IDLE) && (state_ff != FCS_PEND) &&
        !(state_ff == FCS_PROG && cnt_ff != FCS_CNT_W'(PROG_CYC - 1)) &&
        !(state_ff == FCS_ERASE && cnt_ff != FCS_CNT_W'(ERASE_CYC - 1)) &&
        !(state_ff == FCS_WIPE && cnt_ff != FCS_CNT_W'(ERASE_CYC - 1)) &&
        !(state_ff == FCS_QCHK && !(widx_ff[FCS_WORD_W] && !rd_pend_ff));
    assign lck_set = (state_ff == FCS_PEND) && hsb_i.idle &&
        (((cmd_ff == FCS_C_WP || cmd_ff == FCS_C_EP) && page_locked) ||
        (cmd_ff == FCS_C_EA && wipe_locked));
    // -------------------------------------------------------------------
    // status flags
    // -------------------------------------------------------------------
    // ready drops on the accepted write, rises on completion or refusal
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
            rdy_ff <= 1'b1;
        else if (accept)
            rdy_ff <= 1'b0;
        else if (cmd_done || lck_set)
            rdy_ff <= 1'b1;
    end
    // error flags: a set in the same cycle as the status read wins
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            pge_ff <= 1'b0;
            lck_ff <= 1'b0;
        end
        else
        begin
            if (bad_cmd || busy_hit)
                pge_ff <= 1'b1;
            else if (reg_i.rd && reg_i.addr == FCS_OFS_STAT)
                pge_ff <= 1'b0;
            if (lck_set)
                lck_ff <= 1'b1;
            else if (reg_i.rd && reg_i.addr == FCS_OFS_STAT)
                lck_ff <= 1'b0;
        end
    end
    // quick check result and its interrupt suppression
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            qpr_ff <= 1'b0;
            qirq_ff <= 1'b0;
        end
        else
        begin
            if (state_ff == FCS_QCHK && cmd_done)
                qpr_ff <= qacc_ff;
            if (accept)
                qirq_ff <= (wr_cmd == FCS_C_QPR);
        end
    end
    // -------------------------------------------------------------------
    // control register and page number field
    // -------------------------------------------------------------------
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            rdy_ie_ff <= 1'b0;
            lck_ie_ff <= 1'b0;
            pge_ie_ff <= 1'b0;
        end
        else if (reg_i.wr && reg_i.addr == FCS_OFS_CTRL)
        begin
            rdy_ie_ff <= reg_i.wdata[FCS_CTRL_RDY_IE];
            lck_ie_ff <= reg_i.wdata[FCS_CTRL_LCK_IE];
            pge_ie_ff <= reg_i.wdata[FCS_CTRL_PGE_IE];
        end
    end
    // buffer writes track the page of the latest word; direct writes too
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
            page_number_field_ff <= '0;
        else if (accept)
            page_number_field_ff <= reg_i.wdata[FCS_PAGE_NUMBER_FIELD_LSB +: FCS_PAGE_NUMBER_FIELD_W];
        else if (pbuf_wr)
            page_number_field_ff <= FCS_PAGE_NUMBER_FIELD_W'(hsb_i.addr[FCS_ADDR_W-1:FCS_WORD_W+2]);
    end
    // -------------------------------------------------------------------
    // fuses: region locks, boot protect
    // -------------------------------------------------------------------
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
            fuse_ff <= FCS_FUSE_RST;
        else if (state_ff == FCS_FUSEW && cmd_ff == FCS_C_LP)
            fuse_ff[tgt_region] <= 1'b0;
        else if (state_ff == FCS_FUSEW && cmd_ff == FCS_C_UP)
            fuse_ff[tgt_region] <= 1'b1;
        else if (state_ff == FCS_WIPE && cmd_done)
            fuse_ff <= FCS_FUSE_RST;
    end
    // -------------------------------------------------------------------
    // page buffer
    // -------------------------------------------------------------------
    // bytes and halfwords are not decoded; every write is treated as a word
    for (genvar i = 0; i < FCS_WORDS; i++)
    begin : g_pbuf
        always_ff @(posedge clock_i or posedge rst_i)
        begin
            if (rst_i)
                pbuf_ff[i] <= FCS_ONES;
            else if (state_ff == FCS_FUSEW && cmd_ff == FCS_C_CPB)
                pbuf_ff[i] <= FCS_ONES;
            else if (pbuf_wr && hsb_i.addr[FCS_WORD_W+1:2] == FCS_WORD_W'(i))
                pbuf_ff[i] <= pbuf_ff[i] & hsb_i.wdata;
        end
    end
    // -------------------------------------------------------------------
    // array requests
    // -------------------------------------------------------------------
    // program streams the buffer word by word from the counter's low bits
    always_comb
    begin
        arr_o = '0;
        arr_o.page = tgt_page;
        arr_o.word = (state_ff == FCS_QCHK) ? widx_ff[FCS_WORD_W-1:0] :
            cnt_ff[FCS_WORD_W-1:0];
        arr_o.data = pbuf_ff[cnt_ff[FCS_WORD_W-1:0]];
        arr_o.wr = (state_ff == FCS_PROG) && (cnt_ff < FCS_CNT_W'(FCS_WORDS));
        arr_o.erase = (state_ff == FCS_ERASE) && (cnt_ff == '0);
        arr_o.wipe = (state_ff == FCS_WIPE) && wipe_ph_ff && (cnt_ff == FCS_CNT_W'(1));
        arr_o.rd = (state_ff == FCS_QCHK) && !widx_ff[FCS_WORD_W];
    end
    assign vol_wipe_o = (state_ff == FCS_WIPE) && !wipe_ph_ff;
    assign sec_erase_o = (state_ff == FCS_WIPE) && cmd_done && sec_bit_i;
    assign fuses_o = fuse_ff;
    // -------------------------------------------------------------------
    // register read port and interrupt
    // -------------------------------------------------------------------
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
            rdata_ff <= '0;
        else if (reg_i.rd)
        begin
            unique case (reg_i.addr)
                FCS_OFS_CTRL: rdata_ff <= 32'(rdy_ie_ff) << FCS_CTRL_RDY_IE |
                    32'(lck_ie_ff) << FCS_CTRL_LCK_IE | 32'(pge_ie_ff) << FCS_CTRL_PGE_IE;
                FCS_OFS_CMD: rdata_ff <= 32'(page_number_field_ff) << FCS_PAGE_NUMBER_FIELD_LSB | 32'(cmd_ff);
                FCS_OFS_STAT: rdata_ff <= 32'(rdy_ff) << FCS_ST_RDY |
                    32'(lck_ff) << FCS_ST_LCK | 32'(pge_ff) << FCS_ST_PGE |
                    32'(qpr_ff) << FCS_ST_QPR;
                FCS_OFS_FUSE: rdata_ff <= fuse_ff;
                default: rdata_ff <= '0;
            endcase
        end
        else
            rdata_ff <= '0;
    end
    assign reg_rdata_o = rdata_ff;
    // level interrupt from flags and enables
    assign irq_o = (rdy_ff && rdy_ie_ff && !qirq_ff) || (lck_ff && lck_ie_ff) ||
        (pge_ff && pge_ie_ff);
endmodule // fcs_sequencer

// ---- inc/fcs_pkg.sv ----
// fcs_pkg: constants, states and carriers of the flash command sequencer
// assumes: one 40 MHz clock domain, a flash array model outside the block
package fcs_pkg;
    // -------------------------------------------------------------------
    // geometry
    // -------------------------------------------------------------------
    localparam int FCS_PAGES = 512;
    localparam int FCS_PAGE_W = 9;
    localparam int FCS_WORDS = 128;
    localparam int FCS_WORD_W = 7;
    localparam int FCS_REGIONS = 16;
    localparam int FCS_REGION_W = 4;
    localparam int FCS_PAGE_NUMBER_FIELD_W = 16;
    localparam int FCS_CMD_W = 6;
    localparam int FCS_BP_W = 3;
    localparam int FCS_FUSE_W = 32;
    localparam int FCS_ADDR_W = 22;
    localparam logic [FCS_PAGE_W-1:0] FCS_USER_PAGE_SEL = 9'h1FF;
    // -------------------------------------------------------------------
    // register offsets (byte addresses)
    // -------------------------------------------------------------------
    localparam logic [7:0] FCS_OFS_CTRL = 8'h00;
    localparam logic [7:0] FCS_OFS_CMD = 8'h04;
    localparam logic [7:0] FCS_OFS_STAT = 8'h08;
    localparam logic [7:0] FCS_OFS_FUSE = 8'h0C;
    // -------------------------------------------------------------------
    // field positions
    // -------------------------------------------------------------------
    localparam int FCS_KEY_LSB = 24;
    localparam int FCS_PAGE_NUMBER_FIELD_LSB = 8;
    localparam int FCS_CTRL_RDY_IE = 0;
    localparam int FCS_CTRL_LCK_IE = 2;
    localparam int FCS_CTRL_PGE_IE = 3;
    localparam int FCS_ST_RDY = 0;
    localparam int FCS_ST_LCK = 2;
    localparam int FCS_ST_PGE = 3;
    localparam int FCS_ST_QPR = 5;
    localparam int FCS_BP_LSB = 17;
    // -------------------------------------------------------------------
    // key and command codes (values arbitrary)
    // -------------------------------------------------------------------
    localparam logic [7:0] FCS_KEY = 8'h5A;
    localparam logic [FCS_CMD_W-1:0] FCS_C_NOP = 6'h00;
    localparam logic [FCS_CMD_W-1:0] FCS_C_WP = 6'h01;
    localparam logic [FCS_CMD_W-1:0] FCS_C_EP = 6'h02;
    localparam logic [FCS_CMD_W-1:0] FCS_C_CPB = 6'h03;
    localparam logic [FCS_CMD_W-1:0] FCS_C_LP = 6'h04;
    localparam logic [FCS_CMD_W-1:0] FCS_C_UP = 6'h05;
    localparam logic [FCS_CMD_W-1:0] FCS_C_EA = 6'h06;
    localparam logic [FCS_CMD_W-1:0] FCS_C_QPR = 6'h0C;
    // -------------------------------------------------------------------
    // timing: program/erase step times, 40 MHz clock
    // -------------------------------------------------------------------
    localparam int FCS_CLK_MHZ = 40;
    localparam int FCS_T_PROG_US = 4000;
    localparam int FCS_T_ERASE_US = 8000;
    localparam int FCS_PROG_CYC = FCS_T_PROG_US * FCS_CLK_MHZ;
    localparam int FCS_ERASE_CYC = FCS_T_ERASE_US * FCS_CLK_MHZ;
    localparam int FCS_CNT_W = 20;
    localparam logic [FCS_FUSE_W-1:0] FCS_FUSE_RST = 32'hFFFFFFFF;
    localparam logic [31:0] FCS_ONES = 32'hFFFFFFFF;
    // -------------------------------------------------------------------
    // types
    // -------------------------------------------------------------------
    typedef enum logic [2:0] {
        FCS_IDLE, FCS_PEND, FCS_PROG, FCS_ERASE, FCS_WIPE, FCS_QCHK, FCS_FUSEW
    } fcs_state_t;
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } fcs_reg_req_t;
    typedef struct packed {
        logic [FCS_ADDR_W-1:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic idle;
    } fcs_hsb_req_t;
    typedef struct packed {
        logic [FCS_PAGE_W-1:0] page;
        logic [FCS_WORD_W-1:0] word;
        logic [31:0] data;
        logic wr;
        logic erase;
        logic wipe;
        logic rd;
    } fcs_arr_req_t;
endpackage

// ---- tb/fcs_array_model.sv ----
// fcs_array_model: behavioural flash array behind the sequencer
// assumes: requests on arr_i are sampled at each rising clock edge
`timescale 1ns/10ps
module fcs_array_model
    import fcs_pkg::*;
(
    input wire logic clock_i,
    input wire fcs_arr_req_t arr_i,
    output logic [31:0] rdata_o
);
    // ----
    // storage, absent key reads as erased
    // ----
    logic [31:0] mem [int];
    function automatic logic [31:0] peek(input int pg, input int wd);
        int k;
        k = pg * FCS_WORDS + wd;
        return mem.exists(k) ? mem[k] : FCS_ONES;
    endfunction
    // program clears bits only, erase restores ones
    always @(posedge clock_i)
    begin
        int k;
        k = int'(arr_i.page) * FCS_WORDS + int'(arr_i.word);
        if (arr_i.wr)
            mem[k] = peek(int'(arr_i.page), int'(arr_i.word)) & arr_i.data;
        if (arr_i.erase)
            for (int w = 0; w < FCS_WORDS; w++)
                mem.delete(int'(arr_i.page) * FCS_WORDS + w);
        if (arr_i.wipe)
            for (int p = 0; p < FCS_PAGES; p++)
                for (int w = 0; w < FCS_WORDS; w++)
                    if (p != int'(FCS_USER_PAGE_SEL))
                        mem.delete(p * FCS_WORDS + w);
        // answer one cycle late, toggle otherwise so stale data never matches
        rdata_o <= arr_i.rd ? peek(int'(arr_i.page), int'(arr_i.word)) : ~rdata_o;
    end
endmodule // fcs_array_model

// ---- tb/fcs_sequencer_sva.sv ----
// fcs_sequencer_sva: port-level checks of the flash command sequencer
// assumes: bound to fcs_sequencer, single clock domain
`timescale 1ns/10ps
module fcs_sequencer_sva
    import fcs_pkg::*;
#(
    parameter int PROG_CYC = FCS_PROG_CYC,
    parameter int ERASE_CYC = FCS_ERASE_CYC
)(
    input wire logic clock_i,
    input wire logic rst_i,
    input wire fcs_reg_req_t reg_i,
    input wire logic [31:0] reg_rdata_o,
    input wire fcs_hsb_req_t hsb_i,
    input wire fcs_arr_req_t arr_o,
    input wire logic [31:0] arr_rdata_i,
    input wire logic sec_bit_i,
    input wire logic sec_erase_o,
    input wire logic vol_wipe_o,
    input wire logic [FCS_FUSE_W-1:0] fuses_o,
    input wire logic irq_o
);
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (rst_i);
    // ----
    // page write walks words in order
    // ----
    sequence s_word_mid;
        arr_o.wr && arr_o.word != 7'h7F;
    endsequence
    sequence s_word_next;
        arr_o.wr && arr_o.word == $past(arr_o.word) + 7'h01;
    endsequence
    rdata_idle_a: assert property (!reg_i.rd |=> reg_rdata_o == 32'h0)
        else $error("read data not zero outside read");
    busy_status_a: assert property (reg_i.rd && reg_i.addr == FCS_OFS_STAT && arr_o.wr
        |=> !reg_rdata_o[FCS_ST_RDY]) else $error("ready seen while programming");
    start_idle_a: assert property ($rose(arr_o.wr) |-> $past(hsb_i.idle))
        else $error("command started without idle bus cycle");
    word_first_a: assert property ($rose(arr_o.wr) |-> arr_o.word == 7'h00)
        else $error("page write not starting at word zero");
    word_step_a: assert property (s_word_mid |=> s_word_next)
        else $error("page write word order broken");
    word_last_a: assert property (arr_o.wr && arr_o.word == 7'h7F |=> !arr_o.wr)
        else $error("page write past last word");
    // locked region or boot area never touched, user page exempt
    lock_guard_a: assert property ((arr_o.wr || arr_o.erase)
        && arr_o.page != FCS_USER_PAGE_SEL |-> fuses_o[arr_o.page[8:5]]
        && (fuses_o[FCS_BP_LSB+:FCS_BP_W] == 3'h7
        || arr_o.page >= (9'h080 >> fuses_o[FCS_BP_LSB+:FCS_BP_W])))
        else $error("write or erase hit a protected page");
    wipe_free_a: assert property (arr_o.wipe |-> fuses_o[15:0] == 16'hFFFF
        && fuses_o[FCS_BP_LSB+:FCS_BP_W] == 3'h7) else $error("wipe while protected");
    vol_first_a: assert property ($rose(arr_o.wipe) |-> $past(vol_wipe_o))
        else $error("array wiped before volatile storage");
    sec_late_a: assert property (sec_erase_o |-> !vol_wipe_o && !arr_o.wipe)
        else $error("security bit erased too early");
endmodule // fcs_sequencer_sva

// ---- tb/tb.sv ----
// tb: self-checking bench of the flash command sequencer
// assumes: array model answers reads, short program and erase counts
`timescale 1ns/10ps
module tb
    import fcs_pkg::*;
();
    logic clock_i = 1'b0;
    logic rst_i = 1'b1;
    fcs_reg_req_t reg_i = '0;
    fcs_hsb_req_t hsb_i = '{addr: '0, wdata: '0, wr: 1'b0, idle: 1'b1};
    logic [31:0] reg_rdata_o;
    logic [31:0] arr_rdata_i;
    logic [31:0] st;
    fcs_arr_req_t arr_o;
    logic sec_erase_o;
    logic vol_wipe_o;
    logic irq_o;
    logic sec_seen = 1'b0;
    logic [FCS_FUSE_W-1:0] fuses_o;
    int failures = 0;
    int n_checks = 0;
    fcs_sequencer #(.PROG_CYC(200), .ERASE_CYC(300)) fcs_sequencer_inst (.clock_i(clock_i),
        .rst_i(rst_i), .reg_i(reg_i), .reg_rdata_o(reg_rdata_o), .hsb_i(hsb_i),
        .arr_o(arr_o), .arr_rdata_i(arr_rdata_i), .sec_bit_i(1'b1),
        .sec_erase_o(sec_erase_o), .vol_wipe_o(vol_wipe_o), .fuses_o(fuses_o), .irq_o(irq_o));
    fcs_array_model fcs_array_model_inst (.clock_i(clock_i), .arr_i(arr_o),
        .rdata_o(arr_rdata_i));
    // ----
    // clock and helpers
    // ----
    initial
    begin
        forever #12.5 clock_i = ~clock_i;
    end
    // security erase is a pulse, so latch it
    always @(posedge clock_i)
    begin
        if (sec_erase_o === 1'b1)
            sec_seen <= 1'b1;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        $display("checks=%0d mismatches=%0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_i);
        reg_i <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clock_i);
        reg_i.wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clock_i);
        reg_i <= '{addr: a, wdata: '0, wr: 1'b0, rd: 1'b1};
        @(posedge clock_i);
        reg_i.rd <= 1'b0;
        #1 d = reg_rdata_o;
    endtask
    task automatic cmd(input logic [5:0] c, input logic [15:0] pg);
        wr(FCS_OFS_CMD, {FCS_KEY, pg, 2'b00, c});
    endtask
    // poll status; error bits gathered since each read clears them
    task automatic wait_rdy(output logic [31:0] s);
        logic [31:0] d;
        logic [31:0] acc;
        acc = '0;
        d = '0;
        for (int i = 0; i < 1000 && d[FCS_ST_RDY] !== 1'b1; i++)
        begin
            rd(FCS_OFS_STAT, d);
            acc = acc | d;
        end
        if (d[FCS_ST_RDY] !== 1'b1)
        begin
            failures++;
            finish_test();
        end
        s = d | (acc & 32'h0000000C);
    endtask
    task automatic hsb_wr(input logic [21:0] a, input logic [31:0] d);
        @(posedge clock_i);
        hsb_i <= '{addr: a, wdata: d, wr: 1'b1, idle: 1'b0};
        @(posedge clock_i);
        hsb_i <= '{addr: a, wdata: d, wr: 1'b0, idle: 1'b1};
    endtask
    // ----
    // scenarios
    // ----
    task automatic t_errors();
        wr(FCS_OFS_CMD, {8'h00, 16'h0003, 2'b00, FCS_C_WP});
        wait_rdy(st);
        chk(st[FCS_ST_PGE], 1'b1);
        rd(FCS_OFS_STAT, st);
        chk(st[FCS_ST_PGE], 1'b0);
        cmd(6'h3F, 16'h0003);
        wait_rdy(st);
        chk(st[FCS_ST_PGE], 1'b1);
        rd(8'h30, st);
        chk(st, 32'h0);
        rd(FCS_OFS_FUSE, st);
        chk(st, FCS_FUSE_RST);
        $display("errors test done");
    endtask
    task automatic t_prog();
        cmd(FCS_C_CPB, 16'h0003);
        wait_rdy(st);
        hsb_wr({13'd3, 7'd5, 2'b00}, 32'hF0F0FFFF);
        hsb_wr({13'd7, 7'd5, 2'b00}, 32'hFFFF0F0F);
        rd(FCS_OFS_CMD, st);
        chk(st[23:8], 16'h0007);
        @(posedge clock_i);
        hsb_i.idle <= 1'b0;
        cmd(FCS_C_WP, 16'h0003);
        rd(FCS_OFS_STAT, st);
        chk(st[FCS_ST_RDY], 1'b0);
        chk(arr_o.wr, 1'b0);
        @(posedge clock_i);
        hsb_i.idle <= 1'b1;
        repeat (3) @(posedge clock_i);
        cmd(FCS_C_EP, 16'h0004);
        wait_rdy(st);
        chk(st[FCS_ST_PGE], 1'b1);
        chk(fcs_array_model_inst.peek(3, 5), 32'hF0F00F0F);
        chk(fcs_array_model_inst.peek(3, 4), FCS_ONES);
        chk(irq_o, 1'b1);
        $display("program test done");
    endtask
    task automatic t_qchk();
        cmd(FCS_C_QPR, 16'h0003);
        wait_rdy(st);
        chk(st[FCS_ST_QPR], 1'b0);
        chk(irq_o, 1'b0);
        cmd(FCS_C_QPR, 16'h0004);
        wait_rdy(st);
        chk(st[FCS_ST_QPR], 1'b1);
        $display("quick check test done");
    endtask
    task automatic t_lock();
        cmd(FCS_C_LP, 16'd40);
        wait_rdy(st);
        chk(fuses_o[15:0], 16'hFFFD);
        cmd(FCS_C_LP, 16'h0003);
        wait_rdy(st);
        chk(fuses_o[0], 1'b0);
        cmd(FCS_C_WP, 16'h0005);
        wait_rdy(st);
        chk(st[FCS_ST_LCK], 1'b1);
        chk(fcs_array_model_inst.peek(5, 5), FCS_ONES);
        wr(FCS_OFS_CTRL, 32'h4);
        cmd(FCS_C_EA, 16'h0);
        for (int i = 0; i < 50 && irq_o !== 1'b1; i++)
            @(posedge clock_i);
        chk(irq_o, 1'b1);
        if (irq_o !== 1'b1)
            finish_test();
        wait_rdy(st);
        chk(st[FCS_ST_LCK], 1'b1);
        chk(irq_o, 1'b0);
        chk(fcs_array_model_inst.peek(3, 5), 32'hF0F00F0F);
        cmd(FCS_C_UP, 16'd40);
        wait_rdy(st);
        cmd(FCS_C_UP, 16'h0003);
        wait_rdy(st);
        chk(fuses_o[15:0], 16'hFFFF);
        $display("lock test done");
    endtask
    task automatic t_erase();
        wr(FCS_OFS_CTRL, 32'h1);
        cmd(FCS_C_EP, 16'h0003);
        wait_rdy(st);
        chk(fcs_array_model_inst.peek(3, 5), FCS_ONES);
        cmd(FCS_C_WP, 16'h0003);
        wait_rdy(st);
        cmd(FCS_C_WP, 16'h01FF);
        wait_rdy(st);
        chk(fcs_array_model_inst.peek(511, 5), 32'hF0F00F0F);
        cmd(FCS_C_EA, 16'h0);
        wait_rdy(st);
        chk(fcs_array_model_inst.peek(3, 5), FCS_ONES);
        chk(fcs_array_model_inst.peek(511, 5), 32'hF0F00F0F);
        chk(fuses_o, FCS_FUSE_RST);
        chk(sec_seen, 1'b1);
        $display("erase test done");
    endtask
    // main sequence
    initial
    begin
        repeat (8) @(posedge clock_i);
        rst_i <= 1'b0;
        wr(FCS_OFS_CTRL, 32'h1);
        t_errors();
        t_prog();
        t_qchk();
        t_lock();
        t_erase();
        finish_test();
    end
endmodule // tb
bind fcs_sequencer fcs_sequencer_sva #(.PROG_CYC(PROG_CYC), .ERASE_CYC(ERASE_CYC)) sva_inst (
    .clock_i(clock_i), .rst_i(rst_i), .reg_i(reg_i), .reg_rdata_o(reg_rdata_o),
    .hsb_i(hsb_i), .arr_o(arr_o), .arr_rdata_i(arr_rdata_i), .sec_bit_i(sec_bit_i),
    .sec_erase_o(sec_erase_o), .vol_wipe_o(vol_wipe_o), .fuses_o(fuses_o), .irq_o(irq_o));
